// ---- tcc_pkg.sv ----
// Constants, register map and carrier types for the timer compare/capture block
// Operation
// - Each compare value is compared with the counter; equality drives flag and waveform.
// - Compare writes stage the high byte in one shared 8-bit latch.
// - Capture reads return the high byte through the shared latch, same instant.
// - A qualifying capture event copies the counter; timer a may use comparator.
// - Capture used as top: capture flag sets when counter reaches top instead.
// - Mask bits: capture 5, match c 3, b 2, a 1, overflow 0.
// - Interrupt request needs flag set, mask bit set and global enable.
// - Flag bits: capture 5, match c 3, b 2, a 1, overflow 0; reset zero.
// - Bits 7, 6 and 4 of mask and flags are read-only zero.
// - Capture flag sets on pin capture event when capture is not top.
// - Match flag sets one timer cycle after counter equals compare value.
// - A forced match strobe never sets a match flag.
// - Each flag clears when its interrupt vector is executed.
// - Writing one clears a flag; writing zero leaves it.
// - Overflow flag follows the counter core's overflow event per waveform mode.
// - Mask and flag layouts are identical for both timers.
// - Forced match raises no interrupt and does not clear the counter.
package tcc_pkg;

  localparam int NUM_TIMERS = 2;
  localparam int ADDR_W = 8;

  // Per-timer register offsets, timer i at base i*16
  localparam logic [3:0] OFS_CAP_LO = 4'h0;
  localparam logic [3:0] OFS_CAP_HI = 4'h1;
  localparam logic [3:0] OFS_CMP_LO = 4'h2;
  localparam logic [3:0] OFS_MASK = 4'h8;
  localparam logic [3:0] OFS_FLAGS = 4'h9;
  localparam logic [3:0] OFS_CTRL = 4'hA;
  localparam logic [3:0] OFS_FORCE = 4'hB;
  localparam logic [7:0] ADDR_EVT_STATUS = 8'h20;
  localparam logic [7:0] ADDR_EVT_MASK = 8'h21;

  // Mask and flag bit positions, shared by both timers
  localparam int BIT_OVF = 0;
  localparam int BIT_MATCH_A = 1;
  localparam int BIT_CAPTURE = 5;
  localparam logic [7:0] IRQ_BITS_USED = 8'h2F;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [15:0] VALUE_RESET = 16'h0000;

  // Control register: bit0 rising edge select, bit1 comparator source
  localparam int CTRL_EDGE_RISING = 0;
  localparam int CTRL_USE_COMPARATOR = 1;
  // Force register: bits 7, 6, 5 force match a, b, c
  localparam int FORCE_A_BIT = 7;

  // Waveform modes where the capture register is the top value
  localparam logic [3:0] WGM_CAP_TOP_0 = 4'h8;
  localparam logic [3:0] WGM_CAP_TOP_1 = 4'hA;
  localparam logic [3:0] WGM_CAP_TOP_2 = 4'hC;
  localparam logic [3:0] WGM_CAP_TOP_3 = 4'hE;

  typedef struct packed {
    logic [15:0] counter_value;
    logic tick;
    logic top_hit;
    logic overflow;
    logic [3:0] waveform_mode_bits;
  } tcc_core_t;

  typedef struct packed {
    logic [2:0] match;
    logic [2:0] force_match;
  } tcc_wave_t;

  typedef struct packed {
    logic [15:0] capture_value;
    logic [2:0][15:0] compare_value;
    logic [7:0] mask;
    logic [7:0] flags;
    logic [1:0] ctrl;
    logic [2:0] pend;
    logic [2:0] force_match;
    logic [2:0] pin_sync;
    logic pin_level;
  } tcc_timer_t;

  typedef struct packed {
    tcc_timer_t [NUM_TIMERS-1:0] t;
    logic [7:0] hold;
    logic [7:0] rdata;
    logic [2:0] comp_sync;
    logic comp_level;
    logic [NUM_TIMERS-1:0] evt;
    logic [NUM_TIMERS-1:0] evt_mask;
  } tcc_state_t;

endpackage : tcc_pkg

// ---- tcc_timer16.sv ----
// Compare, capture and interrupt flag logic for the two 16-bit timers
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ps
module tcc_timer16 (
  input wire logic clock,
  input wire logic reset,
  input wire logic [tcc_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire tcc_pkg::tcc_core_t [tcc_pkg::NUM_TIMERS-1:0] core,
  input wire logic [tcc_pkg::NUM_TIMERS-1:0] capture_pin,
  input wire logic comparator_out,
  input wire logic global_irq_enable,
  input wire logic [tcc_pkg::NUM_TIMERS-1:0][7:0] vector_ack,
  output tcc_pkg::tcc_wave_t [tcc_pkg::NUM_TIMERS-1:0] wave,
  output logic [tcc_pkg::NUM_TIMERS-1:0][7:0] irq_req,
  output logic irq
);
  import tcc_pkg::*;

  tcc_state_t s_r;
  tcc_state_t s_nxt;

  always_comb begin
    logic hit;
    logic [3:0] ofs;
    logic cap_top;
    logic src_agree;
    logic src_s3;
    logic src_level;
    logic cap_edge;
    logic [7:0] set_v;
    logic [7:0] clr_v;
    int ch;
    logic [NUM_TIMERS-1:0] evt_set;
    hit = 1'b0;
    ofs = addr[3:0];
    cap_top = 1'b0;
    src_agree = 1'b0;
    src_s3 = 1'b0;
    src_level = 1'b0;
    cap_edge = 1'b0;
    set_v = '0;
    clr_v = '0;
    ch = 0;
    evt_set = '0;
    s_nxt = s_r;
    s_nxt.rdata = 8'h00;
    // Comparator source, synchronised like a pin
    s_nxt.comp_sync = {s_r.comp_sync[1:0], comparator_out};
    if (s_r.comp_sync[1] == s_r.comp_sync[2]) begin
      s_nxt.comp_level = s_r.comp_sync[2];
    end
    for (int i = 0; i < NUM_TIMERS; i++) begin
      hit = (addr[7:4] == 4'(i));
      set_v = '0;
      s_nxt.t[i].force_match = 3'h0;
      s_nxt.t[i].pin_sync = {s_r.t[i].pin_sync[1:0], capture_pin[i]};
      // Modes that use the capture register as top disconnect the pin
      unique case (core[i].waveform_mode_bits)
        WGM_CAP_TOP_0: begin
          cap_top = 1'b1;
        end
        WGM_CAP_TOP_1: begin
          cap_top = 1'b1;
        end
        WGM_CAP_TOP_2: begin
          cap_top = 1'b1;
        end
        WGM_CAP_TOP_3: begin
          cap_top = 1'b1;
        end
        default: begin
          cap_top = 1'b0;
        end
      endcase
      // Edge counts once second and third stage agree on a new level
      if (i == 0 && s_r.t[i].ctrl[CTRL_USE_COMPARATOR]) begin
        src_agree = (s_r.comp_sync[1] == s_r.comp_sync[2]);
        src_s3 = s_r.comp_sync[2];
        src_level = s_r.comp_level;
      end else begin
        src_agree = (s_r.t[i].pin_sync[1] == s_r.t[i].pin_sync[2]);
        src_s3 = s_r.t[i].pin_sync[2];
        src_level = s_r.t[i].pin_level;
      end
      if (s_r.t[i].pin_sync[1] == s_r.t[i].pin_sync[2]) begin
        s_nxt.t[i].pin_level = s_r.t[i].pin_sync[2];
      end
      cap_edge = src_agree && (src_s3 != src_level) &&
                 (src_s3 == s_r.t[i].ctrl[CTRL_EDGE_RISING]);
      // Pin is disconnected while capture serves as top
      if (cap_edge && !cap_top) begin
        s_nxt.t[i].capture_value = core[i].counter_value;
        set_v[BIT_CAPTURE] = 1'b1;
      end
      if (cap_top && core[i].tick && core[i].top_hit) begin
        set_v[BIT_CAPTURE] = 1'b1;
      end
      // Match seen on one timer tick, flagged on the next
      for (int c = 0; c < 3; c++) begin
        if (core[i].tick) begin
          s_nxt.t[i].pend[c] =
            (core[i].counter_value == s_r.t[i].compare_value[c]);
          if (s_r.t[i].pend[c]) begin
            set_v[BIT_MATCH_A + c] = 1'b1;
          end
        end
      end
      if (core[i].tick && core[i].overflow) begin
        set_v[BIT_OVF] = 1'b1;
      end
      clr_v = vector_ack[i];
      if (wr && hit) begin
        unique case (ofs)
          OFS_CAP_LO: begin
            s_nxt.t[i].capture_value = {s_r.hold, wdata};
          end
          OFS_MASK: begin
            s_nxt.t[i].mask = wdata & IRQ_BITS_USED;
          end
          OFS_FLAGS: begin
            clr_v = clr_v | wdata;
          end
          OFS_CTRL: begin
            s_nxt.t[i].ctrl = wdata[1:0];
          end
          OFS_FORCE: begin
            // Goes to the waveform unit only: no flag, no counter clear
            for (int c = 0; c < 3; c++) begin
              s_nxt.t[i].force_match[c] = wdata[FORCE_A_BIT - c];
            end
          end
          default: begin
            if (ofs >= OFS_CMP_LO && ofs < OFS_MASK && !ofs[0]) begin
              ch = (int'(ofs) - int'(OFS_CMP_LO)) / 2;
              s_nxt.t[i].compare_value[ch] = {s_r.hold, wdata};
            end
          end
        endcase
      end
      // Hardware set wins over any same-cycle clear
      s_nxt.t[i].flags =
        ((s_r.t[i].flags & ~clr_v) | set_v) & IRQ_BITS_USED;
      evt_set[i] = (set_v != 8'h00);
      if (evt_set[i]) begin
        s_nxt.evt[i] = 1'b1;
      end
      if (rd && hit) begin
        unique case (ofs)
          OFS_CAP_LO: begin
            s_nxt.rdata = s_r.t[i].capture_value[7:0];
            s_nxt.hold = s_r.t[i].capture_value[15:8];
          end
          OFS_MASK: begin
            s_nxt.rdata = s_r.t[i].mask;
          end
          OFS_FLAGS: begin
            s_nxt.rdata = s_r.t[i].flags;
          end
          OFS_CTRL: begin
            s_nxt.rdata = {6'h00, s_r.t[i].ctrl};
          end
          default: begin
            if (ofs == OFS_CAP_HI) begin
              s_nxt.rdata = s_r.hold;
            end else if (ofs >= OFS_CMP_LO && ofs < OFS_MASK) begin
              ch = (int'(ofs) - int'(OFS_CMP_LO)) / 2;
              s_nxt.rdata = ofs[0] ? s_r.t[i].compare_value[ch][15:8] :
                                     s_r.t[i].compare_value[ch][7:0];
            end
          end
        endcase
      end
    end
    // Any high-byte write parks in the shared latch for the next low write
    // Only the 16-bit high-byte offsets feed the latch, not flags or force
    if (wr && addr[7:4] < 4'(NUM_TIMERS) && addr[0] && ofs < OFS_MASK) begin
      s_nxt.hold = wdata;
    end
    if (wr && addr == ADDR_EVT_MASK) begin
      s_nxt.evt_mask = wdata[NUM_TIMERS-1:0];
    end
    if (rd && addr == ADDR_EVT_MASK) begin
      s_nxt.rdata = 8'(s_r.evt_mask);
    end
    if (rd && addr == ADDR_EVT_STATUS) begin
      s_nxt.rdata = 8'(s_r.evt);
      // Events arriving this cycle survive the read clear
      s_nxt.evt = evt_set;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      s_r <= '0;
      for (int i = 0; i < NUM_TIMERS; i++) begin
        s_r.t[i].flags <= FLAGS_RESET;
        s_r.t[i].mask <= MASK_RESET;
        s_r.t[i].capture_value <= VALUE_RESET;
      end
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata = s_r.rdata;
  assign irq = |(s_r.evt & s_r.evt_mask);

  always_comb begin
    for (int i = 0; i < NUM_TIMERS; i++) begin
      wave[i].match = s_r.t[i].pend;
      wave[i].force_match = s_r.t[i].force_match;
      irq_req[i] = global_irq_enable ?
                   (s_r.t[i].flags & s_r.t[i].mask) : 8'h00;
    end
  end

endmodule : tcc_timer16

// ---- tcc_timer16_monitor.sv ----
// Port checker for the timer compare/capture block
`timescale 1ns/1ps
module tcc_timer16_mon (
  input wire logic clock,
  input wire logic reset,
  input wire logic [tcc_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire tcc_pkg::tcc_core_t [tcc_pkg::NUM_TIMERS-1:0] core,
  input wire logic global_irq_enable,
  input wire logic [tcc_pkg::NUM_TIMERS-1:0][7:0] vector_ack,
  input wire tcc_pkg::tcc_wave_t [tcc_pkg::NUM_TIMERS-1:0] wave,
  input wire logic [tcc_pkg::NUM_TIMERS-1:0][7:0] irq_req,
  input wire logic irq
);
  import tcc_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  a_irq_gate:
  assert property (!global_irq_enable |-> irq_req == '0)
    else $error("irq request while globally disabled");
  a_reserved_zero:
  assert property (((irq_req[0] | irq_req[1]) & 8'hD0) == 8'h00)
    else $error("reserved request bit set");
  a_match_cause:
  assert property ($rose(irq_req[0][1]) && $past(global_irq_enable) &&
    !$past(wr) |-> $past(wave[0].match[0])) else $error("flag without match");
  a_match_tick:
  assert property ($rose(wave[0].match[0]) |-> $past(core[0].tick))
    else $error("match without timer tick");
  a_force_cause:
  assert property (wave[0].force_match[0] |->
    $past(wr && addr == 8'h0B && wdata[7])) else $error("stray force pulse");
  a_vector_clear:
  assert property (vector_ack[0][0] && !(core[0].overflow && core[0].tick)
    |=> !irq_req[0][0]) else $error("vector did not clear flag");
  a_write_clear:
  assert property (wr && addr == 8'h09 && wdata[1] && !core[0].tick
    |=> !irq_req[0][1]) else $error("write one did not clear");
  a_flag_sticky:
  assert property (irq_req[0][1] && !vector_ack[0][1] &&
    !(wr && addr[7:1] == 7'h04) |=> irq_req[0][1] || !global_irq_enable)
    else $error("flag lost");
  c_match: cover property (irq_req[0][1]);
  c_force: cover property (wave[0].force_match[0]);
  c_irq: cover property (irq);
endmodule : tcc_timer16_mon

bind tcc_timer16 tcc_timer16_mon i_tcc_timer16_mon (.clock, .reset, .addr,
  .wdata, .wr, .core, .global_irq_enable, .vector_ack, .wave, .irq_req, .irq);

// ---- tcc_timer16_tb_top.sv ----
// Self-checking testbench for the timer compare/capture block
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin \
  err_total++; $display("ERROR %0t got %h want %h", $time, got, exp); end end
module tcc_timer16_tb_top;
  import tcc_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [7:0] addr = '0, wdata = '0, rdata;
  logic wr = 1'b0, rd = 1'b0, comparator_out = 1'b0, irq;
  logic global_irq_enable = 1'b1;
  logic [NUM_TIMERS-1:0] capture_pin = '0;
  logic [NUM_TIMERS-1:0][7:0] vector_ack = '0, irq_req;
  tcc_core_t [NUM_TIMERS-1:0] core = '0;
  tcc_wave_t [NUM_TIMERS-1:0] wave;
  int err_total = 0, compares = 0;
  always #12.5 clock = ~clock;
  tcc_timer16 i_tcc_timer16 (.clock, .reset, .addr, .wdata, .wr, .rd,
    .rdata, .core, .capture_pin, .comparator_out, .global_irq_enable,
    .vector_ack, .wave, .irq_req, .irq);
  task automatic give_verdict;
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask : rd_chk
  // ev bit0 raises overflow, bit1 raises top for this one tick
  task automatic tick_at(input int i, input logic [15:0] v,
                         input logic [1:0] ev);
    @(posedge clock);
    core[i].counter_value <= v;
    core[i].tick <= 1'b1;
    {core[i].top_hit, core[i].overflow} <= ev;
    @(posedge clock);
    core[i].tick <= 1'b0;
    {core[i].top_hit, core[i].overflow} <= 2'b00;
    #1;
  endtask : tick_at
  task automatic t_match;
    rd_chk(8'h09, FLAGS_RESET);
    rd_chk(8'h19, FLAGS_RESET);
    rd_chk(8'h3F, 8'h00);
    // High byte alone must not reach the compare register
    wr_reg(8'h03, 8'h12);
    rd_chk(8'h03, 8'h00);
    wr_reg(8'h02, 8'h34);
    rd_chk(8'h03, 8'h12);
    wr_reg(8'h08, 8'hFF);
    rd_chk(8'h08, IRQ_BITS_USED);
    tick_at(0, 16'h1234, 2'b00);
    `CHK(wave[0].match, 3'b001)
    rd_chk(8'h09, 8'h00);
    tick_at(0, 16'h1235, 2'b00);
    `CHK(wave[0].match, 3'b000)
    rd_chk(8'h09, 8'h02);
    @(posedge clock);
    global_irq_enable <= 1'b0;
    #1;
    `CHK(irq_req[0], 8'h00)
    @(posedge clock);
    global_irq_enable <= 1'b1;
    #1;
    `CHK(irq_req[0], 8'h02)
    wr_reg(8'h09, 8'h00);
    rd_chk(8'h09, 8'h02);
    wr_reg(8'h09, 8'h02);
    rd_chk(8'h09, 8'h00);
    wr_reg(8'h0B, 8'hE0);
    `CHK(wave[0].force_match, 3'b111)
    rd_chk(8'h09, 8'h00);
  endtask : t_match
  task automatic t_capture;
    int n;
    wr_reg(8'h0A, 8'h01);
    @(posedge clock);
    core[0].counter_value <= 16'hBEEF;
    capture_pin[0] <= 1'b1;
    for (n = 0; n < 10 && irq_req[0][5] !== 1'b1; n++) begin
      @(posedge clock);
      #1;
    end
    if (n == 10) begin
      err_total++;
      give_verdict();
    end
    rd_chk(8'h00, 8'hEF);
    rd_chk(8'h09, 8'h20);
    rd_chk(8'h01, 8'hBE);
    wr_reg(8'h09, 8'h20);
    @(posedge clock);
    core[0].waveform_mode_bits <= WGM_CAP_TOP_0;
    capture_pin[0] <= 1'b0;
    // Pin filter needs three flops plus the capture stage
    repeat (6) @(posedge clock);
    capture_pin[0] <= 1'b1;
    repeat (6) @(posedge clock);
    rd_chk(8'h09, 8'h00);
    tick_at(0, 16'h0100, 2'b10);
    rd_chk(8'h09, 8'h20);
    wr_reg(8'h09, 8'h20);
    // Comparator source on timer a, falling edge
    @(posedge clock);
    core[0].waveform_mode_bits <= 4'h0;
    core[0].counter_value <= 16'h5A5A;
    comparator_out <= 1'b1;
    wr_reg(8'h0A, 8'h02);
    repeat (6) @(posedge clock);
    #1;
    `CHK(irq_req[0][5], 1'b0)
    @(posedge clock);
    comparator_out <= 1'b0;
    repeat (6) @(posedge clock);
    rd_chk(8'h00, 8'h5A);
    rd_chk(8'h09, 8'h20);
    wr_reg(8'h09, 8'h20);
  endtask : t_capture
  task automatic t_ovf;
    rd_chk(ADDR_EVT_STATUS, 8'h01);
    wr_reg(ADDR_EVT_MASK, 8'h03);
    for (int i = 0; i < NUM_TIMERS; i++) begin
      wr_reg(8'(i * 16 + 8), 8'h01);
      tick_at(i, 16'hFFFF, 2'b01);
      `CHK(irq_req[i], 8'h01)
      @(posedge clock);
      vector_ack[i] <= 8'h01;
      @(posedge clock);
      vector_ack[i] <= 8'h00;
      #1;
      `CHK(irq_req[i], 8'h00)
      `CHK(irq, 1'b1)
      rd_chk(ADDR_EVT_STATUS, 8'(1 << i));
      @(posedge clock);
      #1;
      `CHK(irq, 1'b0)
    end
    // Overflow event and vector clear in one cycle: the set must win
    @(posedge clock);
    core[0].tick <= 1'b1;
    core[0].overflow <= 1'b1;
    vector_ack[0] <= 8'h01;
    @(posedge clock);
    core[0].tick <= 1'b0;
    core[0].overflow <= 1'b0;
    vector_ack[0] <= 8'h00;
    #1;
    `CHK(irq_req[0], 8'h01)
    rd_chk(ADDR_EVT_STATUS, 8'h01);
  endtask : t_ovf
  initial begin
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    t_match();
    t_capture();
    t_ovf();
    give_verdict();
  end
endmodule : tcc_timer16_tb_top
